/* rtl/spfp_programmer.sv */
`timescale 1ns/100ps
module spfp_programmer #(
  parameter int unsigned SYM_CYC = spfp_pkg::SYM_CYC,
  parameter int unsigned GAP_CYC = spfp_pkg::GAP_CYC,
  parameter int unsigned FUSE_CYC = spfp_pkg::FUSE_CYC,
  parameter int unsigned POL_STEPS = 2,
  parameter int unsigned KEY_STEPS = spfp_pkg::KEY_STEPS_MIN
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [spfp_pkg::CODE_W-1:0] cmd_code,
  input wire logic cmd_negative,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_err,
  output logic locked,
  output logic [1:0] supply_level
);
  localparam int unsigned CW = spfp_pkg::CODE_W;

  initial
  begin
    if (POL_STEPS < spfp_pkg::POL_STEPS_MIN || POL_STEPS > spfp_pkg::POL_STEPS_MAX ||
        KEY_STEPS < spfp_pkg::KEY_STEPS_MIN || KEY_STEPS > 255)
      $error("spfp_programmer: unusable key lengths");
  end

  spfp_sym_if sif ();

  spfp_pulse_gen #(
    .SYM_CYC(SYM_CYC),
    .GAP_CYC(GAP_CYC),
    .FUSE_CYC(FUSE_CYC),
    .FUSE_MIN_CYC(spfp_pkg::FUSE_MIN_CYC)
  ) u_pulse_gen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sif(sif)
  );

  spfp_pkg::spfp_st_t st_ff, nxt_st;
  logic [1:0] op_ff, nxt_op;
  logic neg_ff, nxt_neg;
  logic [CW-1:0] mask_ff, nxt_mask;
  logic [7:0] cnt_ff, nxt_cnt;
  logic wait_ff, nxt_wait;
  logic ready_ff, nxt_ready;
  logic done_ff, nxt_done;
  logic err_ff, nxt_err;
  logic locked_ff, nxt_locked;
  logic [CW-1:0] weight;
  logic [7:0] target;
  logic adv;
  logic [7:0] hs_steps_ff;

  assign cmd_ready = ready_ff;
  assign cmd_done = done_ff;
  assign cmd_err = err_ff;
  assign locked = locked_ff;
  assign supply_level = sif.level;

  // ------------------------------------------------------------
  // Symbol selection
  // ------------------------------------------------------------
  // Lowest set bit of what is still to be blown: one fuse per power cycle
  assign weight = mask_ff & CW'(~mask_ff + 1'b1);
  assign adv = wait_ff && sif.done;

  always_comb
  begin
    case (op_ff)
      spfp_pkg::OP_BLOW_LOCK: target = spfp_pkg::LOCK_ADDR;
      spfp_pkg::OP_BLOW_CODE: target = {1'b0, weight};
      default: target = {1'b0, mask_ff};
    endcase
  end

  always_comb
  begin
    sif.sym = spfp_pkg::SYM_STEP;
    sif.req = 1'b0;
    case (st_ff)
      spfp_pkg::ST_OFF: sif.sym = spfp_pkg::SYM_OFF;
      spfp_pkg::ST_POL_HEAD, spfp_pkg::ST_ADR_HEAD, spfp_pkg::ST_KEY_HEAD, spfp_pkg::ST_KEY_TAIL:
        sif.sym = spfp_pkg::SYM_BLOW;
      spfp_pkg::ST_FUSE: sif.sym = spfp_pkg::SYM_FUSE;
      default: sif.sym = spfp_pkg::SYM_STEP;
    endcase
    case (st_ff)
      spfp_pkg::ST_IDLE, spfp_pkg::ST_ADR_SEL, spfp_pkg::ST_ADR_END, spfp_pkg::ST_NEXT: sif.req = 1'b0;
      default: sif.req = !wait_ff;
    endcase
  end

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_neg = neg_ff;
    nxt_mask = mask_ff;
    nxt_cnt = cnt_ff;
    nxt_ready = ready_ff;
    nxt_done = 1'b0;
    nxt_err = 1'b0;
    nxt_locked = locked_ff;
    nxt_wait = wait_ff;
    if (sif.req)
      nxt_wait = 1'b1;
    else if (sif.done)
      nxt_wait = 1'b0;
    case (st_ff)
      spfp_pkg::ST_IDLE:
      begin
        if (cmd_valid && ready_ff)
        begin
          if (cmd_op != spfp_pkg::OP_ADDRESS && locked_ff)
            nxt_err = 1'b1;
          else if (cmd_op == spfp_pkg::OP_BLOW_CODE && cmd_code == '0)
            nxt_done = 1'b1;
          else
          begin
            nxt_ready = 1'b0;
            nxt_op = cmd_op;
            nxt_neg = (cmd_op == spfp_pkg::OP_BLOW_POL) || cmd_negative;
            nxt_mask = (cmd_op == spfp_pkg::OP_BLOW_LOCK || cmd_op == spfp_pkg::OP_BLOW_POL) ? '0 : cmd_code;
            nxt_st = spfp_pkg::ST_OFF;
          end
        end
        else if (!ready_ff && !wait_ff)
          nxt_ready = 1'b1;
      end
      // Each attempt starts from a power cycle, so no stale key or address survives
      spfp_pkg::ST_OFF:
        if (adv)
          nxt_st = neg_ff ? spfp_pkg::ST_POL_HEAD : spfp_pkg::ST_ADR_SEL;
      spfp_pkg::ST_POL_HEAD:
      begin
        if (adv)
        begin
          nxt_st = spfp_pkg::ST_POL_STEP;
          nxt_cnt = 8'(POL_STEPS - 1);
        end
      end
      spfp_pkg::ST_POL_STEP:
      begin
        if (adv)
        begin
          nxt_cnt = cnt_ff - 1'b1;
          if (cnt_ff == '0)
            nxt_st = spfp_pkg::ST_ADR_SEL;
        end
      end
      spfp_pkg::ST_ADR_SEL:
      begin
        if (op_ff == spfp_pkg::OP_BLOW_POL)
          nxt_st = spfp_pkg::ST_KEY_HEAD;
        else if (target == '0)
          nxt_st = spfp_pkg::ST_ADR_END;
        else
        begin
          nxt_st = spfp_pkg::ST_ADR_HEAD;
          nxt_cnt = target - 1'b1;
        end
      end
      spfp_pkg::ST_ADR_HEAD:
        if (adv)
          nxt_st = (cnt_ff == '0) ? spfp_pkg::ST_ADR_END : spfp_pkg::ST_ADR_STEP;
      spfp_pkg::ST_ADR_STEP:
      begin
        if (adv)
        begin
          nxt_cnt = cnt_ff - 1'b1;
          if (cnt_ff == 8'h01)
            nxt_st = spfp_pkg::ST_ADR_END;
        end
      end
      spfp_pkg::ST_ADR_END:
      begin
        if (op_ff == spfp_pkg::OP_ADDRESS)
        begin
          // Supply stays at idle level so the chosen threshold can be measured
          nxt_st = spfp_pkg::ST_IDLE;
          nxt_ready = 1'b1;
          nxt_done = 1'b1;
        end
        else
          nxt_st = spfp_pkg::ST_KEY_HEAD;
      end
      spfp_pkg::ST_KEY_HEAD:
      begin
        if (adv)
        begin
          nxt_st = spfp_pkg::ST_KEY_STEP;
          nxt_cnt = 8'(KEY_STEPS - 1);
        end
      end
      spfp_pkg::ST_KEY_STEP:
      begin
        if (adv)
        begin
          nxt_cnt = cnt_ff - 1'b1;
          if (cnt_ff == '0)
            nxt_st = spfp_pkg::ST_KEY_TAIL;
        end
      end
      spfp_pkg::ST_KEY_TAIL:
        if (adv)
          nxt_st = spfp_pkg::ST_FUSE;
      spfp_pkg::ST_FUSE:
      begin
        if (adv)
        begin
          nxt_st = spfp_pkg::ST_NEXT;
          nxt_mask = mask_ff & ~weight;
          if (op_ff == spfp_pkg::OP_BLOW_LOCK)
            nxt_locked = 1'b1;
        end
      end
      spfp_pkg::ST_NEXT:
      begin
        if (op_ff == spfp_pkg::OP_BLOW_CODE && mask_ff != '0)
          nxt_st = spfp_pkg::ST_OFF;
        else
        begin
          nxt_st = spfp_pkg::ST_IDLE;
          nxt_ready = 1'b1;
          nxt_done = 1'b1;
        end
      end
      default:
        nxt_st = spfp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_ff <= spfp_pkg::ST_IDLE;
      op_ff <= spfp_pkg::OP_ADDRESS;
      neg_ff <= 1'b0;
      mask_ff <= '0;
      cnt_ff <= '0;
      wait_ff <= 1'b0;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      locked_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      neg_ff <= nxt_neg;
      mask_ff <= nxt_mask;
      cnt_ff <= nxt_cnt;
      wait_ff <= nxt_wait;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      locked_ff <= nxt_locked;
    end
  end

  // ------------------------------------------------------------
  // Checks on the pulse sequence
  // ------------------------------------------------------------
  // Step pulses issued since the last blow-level or power-off symbol
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || (sif.req && sif.sym != spfp_pkg::SYM_STEP))
      hs_steps_ff <= '0;
    else if (sif.req && hs_steps_ff != 8'hff)
      hs_steps_ff <= hs_steps_ff + 1'b1;
  end

  sequence s_key_tail_end;
    st_ff == spfp_pkg::ST_KEY_TAIL && adv;
  endsequence

  sequence s_adr_head_more;
    st_ff == spfp_pkg::ST_ADR_HEAD && adv && cnt_ff != '0;
  endsequence

  property p_fuse_after_key;
    @(posedge sys_clk) disable iff (!reset_n)
      s_key_tail_end |=> sif.req && sif.sym == spfp_pkg::SYM_FUSE;
  endproperty
  a_fuse_after_key: assert property (p_fuse_after_key) else $error("Fuse pulse did not follow key");

  property p_key_steps;
    @(posedge sys_clk) disable iff (!reset_n)
      sif.req && st_ff == spfp_pkg::ST_KEY_TAIL |-> hs_steps_ff >= KEY_STEPS;
  endproperty
  a_key_steps: assert property (p_key_steps) else $error("Program key has too few steps");

  property p_pol_key;
    @(posedge sys_clk) disable iff (!reset_n)
      sif.req && neg_ff && st_ff == spfp_pkg::ST_ADR_HEAD
      |-> hs_steps_ff >= spfp_pkg::POL_STEPS_MIN && hs_steps_ff <= spfp_pkg::POL_STEPS_MAX;
  endproperty
  a_pol_key: assert property (p_pol_key) else $error("Polarity key step count out of range");

  property p_addr_steps;
    @(posedge sys_clk) disable iff (!reset_n)
      s_adr_head_more |=> sif.req && sif.sym == spfp_pkg::SYM_STEP;
  endproperty
  a_addr_steps: assert property (p_addr_steps) else $error("Address did not advance by step");

  property p_one_bit;
    @(posedge sys_clk) disable iff (!reset_n)
      sif.req && st_ff == spfp_pkg::ST_FUSE && op_ff == spfp_pkg::OP_BLOW_CODE |-> $onehot(weight);
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("Several code bits in one blow");

  property p_no_fuse_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      sif.req && op_ff == spfp_pkg::OP_ADDRESS |-> sif.sym != spfp_pkg::SYM_FUSE && st_ff != spfp_pkg::ST_KEY_TAIL;
  endproperty
  a_no_fuse_addr: assert property (p_no_fuse_addr) else $error("Fuse sequence while addressing");

  property p_lock_refuse;
    @(posedge sys_clk) disable iff (!reset_n)
      cmd_valid && ready_ff && locked_ff && cmd_op != spfp_pkg::OP_ADDRESS |=> cmd_err && cmd_ready && !cmd_done;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("Blow accepted after lock");

endmodule // spfp_programmer

/* inc/spfp_pkg.sv */
// ------------------------------------------------------------
// Supply pulse fuse programmer constants
// ------------------------------------------------------------
package spfp_pkg;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned SYM_WIDTH_NS = 20000;
  localparam int unsigned GAP_WIDTH_NS = 20000;
  localparam int unsigned FUSE_WIDTH_NS = 300000;
  localparam int unsigned FUSE_MIN_NS = 100000;
  localparam int unsigned SYM_CYC = (SYM_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC = (GAP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FUSE_CYC = (FUSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FUSE_MIN_CYC = (FUSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 17;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned POL_STEPS_MIN = 1;
  localparam int unsigned POL_STEPS_MAX = 6;
  localparam int unsigned KEY_STEPS_MIN = 7;
  localparam logic [7:0] LOCK_ADDR = 8'h80;
  // Supply level driven onto the device pin
  localparam logic [1:0] LVL_OFF = 2'h0;
  localparam logic [1:0] LVL_IDLE = 2'h1;
  localparam logic [1:0] LVL_STEP = 2'h2;
  localparam logic [1:0] LVL_BLOW = 2'h3;
  // Symbols requested from the pulse generator
  localparam logic [1:0] SYM_OFF = 2'h0;
  localparam logic [1:0] SYM_STEP = 2'h1;
  localparam logic [1:0] SYM_BLOW = 2'h2;
  localparam logic [1:0] SYM_FUSE = 2'h3;
  // User commands
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_BLOW_CODE = 2'h1;
  localparam logic [1:0] OP_BLOW_POL = 2'h2;
  localparam logic [1:0] OP_BLOW_LOCK = 2'h3;
  typedef enum logic [1:0] {PG_IDLE, PG_ON, PG_GAP} spfp_pg_st_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_OFF, ST_POL_HEAD, ST_POL_STEP, ST_ADR_SEL, ST_ADR_HEAD, ST_ADR_STEP, ST_ADR_END,
    ST_KEY_HEAD, ST_KEY_STEP, ST_KEY_TAIL, ST_FUSE, ST_NEXT
  } spfp_st_t;
endpackage

/* inc/spfp_sym_if.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Symbol request path between sequencer and pulse generator
// ------------------------------------------------------------
interface spfp_sym_if;
  logic req;
  logic [1:0] sym;
  logic done;
  logic [1:0] level;
  modport seq (output req, output sym, input done, input level);
  modport gen (input req, input sym, output done, output level);
endinterface

/* rtl/spfp_pulse_gen.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Pulse generator: one symbol, then an idle gap
// ------------------------------------------------------------
module spfp_pulse_gen #(
  parameter int unsigned SYM_CYC = spfp_pkg::SYM_CYC,
  parameter int unsigned GAP_CYC = spfp_pkg::GAP_CYC,
  parameter int unsigned FUSE_CYC = spfp_pkg::FUSE_CYC,
  parameter int unsigned FUSE_MIN_CYC = spfp_pkg::FUSE_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  spfp_sym_if.gen sif
);
  localparam int unsigned W = spfp_pkg::CNT_W;
  localparam logic [W-1:0] RUN_MAX = '1;

  initial
  begin
    if (SYM_CYC < 1 || GAP_CYC < 1 || FUSE_CYC < FUSE_MIN_CYC || FUSE_CYC >= (1 << W))
      $error("spfp_pulse_gen: unusable pulse widths");
  end

  spfp_pkg::spfp_pg_st_t st_ff, nxt_st;
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic [1:0] lvl_ff, nxt_lvl;
  logic done_ff, nxt_done;
  logic fuse_ff, nxt_fuse;
  logic [W-1:0] run_ff;

  assign sif.level = lvl_ff;
  assign sif.done = done_ff;

  // ------------------------------------------------------------
  // Symbol timing
  // ------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_lvl = lvl_ff;
    nxt_done = 1'b0;
    nxt_fuse = fuse_ff;
    case (st_ff)
      spfp_pkg::PG_IDLE:
      begin
        if (sif.req)
        begin
          nxt_st = spfp_pkg::PG_ON;
          nxt_fuse = 1'b0;
          case (sif.sym)
            spfp_pkg::SYM_OFF:
            begin
              // Supply removed so the device restarts its key and address state
              nxt_lvl = spfp_pkg::LVL_OFF;
              nxt_cnt = W'(GAP_CYC - 1);
            end
            spfp_pkg::SYM_STEP:
            begin
              nxt_lvl = spfp_pkg::LVL_STEP;
              nxt_cnt = W'(SYM_CYC - 1);
            end
            spfp_pkg::SYM_BLOW:
            begin
              nxt_lvl = spfp_pkg::LVL_BLOW;
              nxt_cnt = W'(SYM_CYC - 1);
            end
            default:
            begin
              nxt_lvl = spfp_pkg::LVL_BLOW;
              nxt_fuse = 1'b1;
              nxt_cnt = W'(FUSE_CYC - 1);
            end
          endcase
        end
      end
      spfp_pkg::PG_ON:
      begin
        if (cnt_ff == '0)
        begin
          nxt_st = spfp_pkg::PG_GAP;
          nxt_lvl = spfp_pkg::LVL_IDLE;
          nxt_cnt = W'(GAP_CYC - 1);
        end
        else
          nxt_cnt = cnt_ff - 1'b1;
      end
      spfp_pkg::PG_GAP:
      begin
        if (cnt_ff == '0)
        begin
          nxt_st = spfp_pkg::PG_IDLE;
          nxt_done = 1'b1;
        end
        else
          nxt_cnt = cnt_ff - 1'b1;
      end
      default:
        nxt_st = spfp_pkg::PG_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st_ff <= spfp_pkg::PG_IDLE;
      cnt_ff <= '0;
      lvl_ff <= spfp_pkg::LVL_OFF;
      done_ff <= 1'b0;
      fuse_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
      done_ff <= nxt_done;
      fuse_ff <= nxt_fuse;
    end
  end

  // ------------------------------------------------------------
  // Checks on the driven supply waveform
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || nxt_lvl != lvl_ff)
      run_ff <= W'(1);
    else if (run_ff != RUN_MAX)
      run_ff <= run_ff + 1'b1;
  end

  property p_sym_width;
    @(posedge sys_clk) disable iff (!reset_n)
      $changed(lvl_ff) && ($past(lvl_ff) == spfp_pkg::LVL_STEP || $past(lvl_ff) == spfp_pkg::LVL_BLOW)
      |-> $past(run_ff) >= SYM_CYC;
  endproperty
  a_sym_width: assert property (p_sym_width) else $error("Symbol pulse too short");

  property p_gap_width;
    @(posedge sys_clk) disable iff (!reset_n)
      $changed(lvl_ff) && $past(lvl_ff) == spfp_pkg::LVL_IDLE |-> $past(run_ff) >= GAP_CYC;
  endproperty
  a_gap_width: assert property (p_gap_width) else $error("Idle gap too short");

  property p_fuse_width;
    @(posedge sys_clk) disable iff (!reset_n)
      $changed(lvl_ff) && $past(fuse_ff) && $past(lvl_ff) == spfp_pkg::LVL_BLOW
      |-> $past(run_ff) >= FUSE_MIN_CYC;
  endproperty
  a_fuse_width: assert property (p_fuse_width) else $error("Fuse pulse too short");

  property p_via_idle;
    @(posedge sys_clk) disable iff (!reset_n)
      $changed(lvl_ff) && (lvl_ff == spfp_pkg::LVL_STEP || lvl_ff == spfp_pkg::LVL_BLOW)
      |-> $past(lvl_ff) == spfp_pkg::LVL_IDLE;
  endproperty
  a_via_idle: assert property (p_via_idle) else $error("Pulse did not start from idle level");

endmodule // spfp_pulse_gen

/* verification/spfp_dev_model.sv */
`timescale 1ns/100ps
// --------------------
// Device model: decodes supply pulses and holds the fuses
// --------------------
module spfp_dev_model #(
  parameter int unsigned SYM_MIN = 3,
  parameter int unsigned GAP_MIN = 3,
  parameter int unsigned FUSE_MIN = 25000
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] supply_level,
  output logic [6:0] code_fuse_ff,
  output logic lock_fuse_ff,
  output logic [7:0] sel_addr,
  output logic sel_neg,
  output logic [7:0] blow_cnt_ff,
  output logic [7:0] fault_cnt_ff
);
  logic [1:0] lvl_ff;
  logic [1:0] keyat_ff;
  logic [7:0] nseg_ff;
  logic [7:0] n0_ff;
  logic [7:0] n1_ff;
  logic [7:0] ncur_ff;
  logic [7:0] fuse_addr;
  logic prog_ff;
  logic [16:0] width_ff;
  int unsigned idle_ff;
  // Limitation: a polarity-bit sequence reads like a short positive address, so it is not modelled
  assign fuse_addr = (keyat_ff == 2'h3) ? n1_ff + 8'h01 : n0_ff + 8'h01;
  // Only the operate code moves; the hysteresis offset is fixed
  assign sel_addr = (nseg_ff == 8'h00) ? 8'h00 : ncur_ff + 8'h01;
  assign sel_neg = (nseg_ff == 8'h02) && (n0_ff >= 8'h01) && (n0_ff <= 8'h06);
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      lvl_ff <= spfp_pkg::LVL_OFF;
      code_fuse_ff <= 7'h00;
      lock_fuse_ff <= 1'b0;
      blow_cnt_ff <= 8'h00;
      fault_cnt_ff <= 8'h00;
      nseg_ff <= 8'h00;
      ncur_ff <= 8'h00;
      n0_ff <= 8'h00;
      n1_ff <= 8'h00;
      keyat_ff <= 2'h0;
      prog_ff <= 1'b0;
      width_ff <= 17'h00000;
      idle_ff <= 0;
    end
    else
    begin
      lvl_ff <= supply_level;
      if (supply_level == spfp_pkg::LVL_OFF)
      begin
        nseg_ff <= 8'h00;
        ncur_ff <= 8'h00;
        prog_ff <= 1'b0;
        idle_ff <= 0;
      end
      else if (supply_level == spfp_pkg::LVL_IDLE)
      begin
        idle_ff <= idle_ff + 1;
        if (lvl_ff == spfp_pkg::LVL_STEP)
        begin
          idle_ff <= 1;
          ncur_ff <= ncur_ff + 8'h01;
          if (width_ff < SYM_MIN)
            fault_cnt_ff <= fault_cnt_ff + 8'h01;
        end
        else if (lvl_ff == spfp_pkg::LVL_BLOW && prog_ff)
        begin
          idle_ff <= 1;
          prog_ff <= 1'b0;
          nseg_ff <= 8'h00;
          blow_cnt_ff <= blow_cnt_ff + 8'h01;
          if (width_ff < FUSE_MIN || lock_fuse_ff || (fuse_addr != 8'h80 && !$onehot(fuse_addr)))
            fault_cnt_ff <= fault_cnt_ff + 8'h01;
          else if (fuse_addr == 8'h80)
            lock_fuse_ff <= 1'b1;
          else
            code_fuse_ff <= code_fuse_ff | fuse_addr[6:0];
        end
        else if (lvl_ff == spfp_pkg::LVL_BLOW)
        begin
          idle_ff <= 1;
          nseg_ff <= nseg_ff + 8'h01;
          ncur_ff <= 8'h00;
          if (nseg_ff == 8'h01)
            n0_ff <= ncur_ff;
          if (nseg_ff == 8'h02)
            n1_ff <= ncur_ff;
          // Key only after an address segment, so addressing alone never arms a blow
          if (nseg_ff >= 8'h02 && ncur_ff >= 8'h07)
          begin
            prog_ff <= 1'b1;
            keyat_ff <= nseg_ff[1:0];
          end
          if (width_ff < SYM_MIN)
            fault_cnt_ff <= fault_cnt_ff + 8'h01;
        end
      end
      else
      begin
        width_ff <= width_ff + 17'h00001;
        if (lvl_ff == spfp_pkg::LVL_IDLE)
        begin
          width_ff <= 17'h00001;
          if (idle_ff < GAP_MIN)
            fault_cnt_ff <= fault_cnt_ff + 8'h01;
        end
        else if (lvl_ff != supply_level)
          fault_cnt_ff <= fault_cnt_ff + 8'h01;
      end
    end
  end
endmodule // spfp_dev_model

/* verification/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
// --------------------
// Testbench
// --------------------
module tb_top;
  localparam int unsigned TIMEOUT = 90000;
  localparam int unsigned WAIT_MAX = 60000;
  localparam logic [6:0] ADR_CODE [4] = '{7'h03, 7'h03, 7'h7f, 7'h01};
  localparam logic ADR_NEG [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic sys_clk, reset_n, cmd_valid, cmd_negative, cmd_ready, cmd_done, cmd_err, locked;
  logic lock_fuse, sel_neg, got_err;
  logic [1:0] cmd_op, supply_level;
  logic [6:0] cmd_code, code_fuse;
  logic [7:0] sel_addr, blow_cnt, fault_cnt;
  int num_errors, checks, cyc_cnt, got_cyc;
  // Key lengths stay at their defaults; the device model's minimum widths match these
  spfp_programmer #(.SYM_CYC(3), .GAP_CYC(3), .FUSE_CYC(25000)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_code(cmd_code),
    .cmd_negative(cmd_negative), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .locked(locked), .supply_level(supply_level));
  spfp_dev_model i_dev (
    .sys_clk(sys_clk), .reset_n(reset_n), .supply_level(supply_level), .code_fuse_ff(code_fuse),
    .lock_fuse_ff(lock_fuse), .sel_addr(sel_addr), .sel_neg(sel_neg), .blow_cnt_ff(blow_cnt),
    .fault_cnt_ff(fault_cnt));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt >= TIMEOUT)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Commands are raised just after an edge and held until the taking edge
  task automatic run_cmd(input logic [1:0] op, input logic [6:0] code, input logic neg);
    int n;
    n = 0;
    // Always let one edge pass so the strobe is never lowered and raised in one step
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_code = code;
    cmd_negative = neg;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    got_cyc = 0;
    while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && got_cyc < WAIT_MAX)
    begin
      @(posedge sys_clk);
      #1;
      got_cyc++;
    end
    got_err = cmd_err;
    `CHK("cmd_finished", 1'b1, (got_cyc < WAIT_MAX))
  endtask
  task automatic t_reset;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("supply_in_reset", spfp_pkg::LVL_OFF, supply_level)
    `CHK("ready_in_reset", 1'b0, cmd_ready)
    reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("ready_first_edge", 1'b1, cmd_ready)
    `CHK("supply_first_edge", spfp_pkg::LVL_OFF, supply_level)
    @(posedge sys_clk);
    #1;
    `CHK("ready_second_edge", 1'b1, cmd_ready)
    `CHK("locked_reset", 1'b0, locked)
  endtask
  task automatic t_address;
    for (int i = 0; i < 4; i++)
    begin
      run_cmd(spfp_pkg::OP_ADDRESS, ADR_CODE[i], ADR_NEG[i]);
      `CHK("sel_addr", {1'b0, ADR_CODE[i]}, sel_addr)
      `CHK("sel_neg", ADR_NEG[i], sel_neg)
      `CHK("no_blow_addressing", 8'h00, blow_cnt)
      `CHK("supply_idle", spfp_pkg::LVL_IDLE, supply_level)
    end
  endtask
  task automatic t_blow_zero;
    run_cmd(spfp_pkg::OP_BLOW_CODE, 7'h00, 1'b0);
    `CHK("zero_code_cycles", 0, got_cyc)
    `CHK("zero_code_blows", 8'h00, blow_cnt)
  endtask
  task automatic t_blow_code;
    run_cmd(spfp_pkg::OP_BLOW_CODE, 7'h05, 1'b0);
    `CHK("code_err", 1'b0, got_err)
    `CHK("code_fuses", 7'h05, code_fuse)
    `CHK("code_blows", 8'h02, blow_cnt)
    `CHK("code_locked", 1'b0, locked)
  endtask
  task automatic t_lock;
    run_cmd(spfp_pkg::OP_BLOW_LOCK, 7'h00, 1'b0);
    `CHK("lock_fuse", 1'b1, lock_fuse)
    `CHK("locked", 1'b1, locked)
    `CHK("lock_blows", 8'h03, blow_cnt)
    `CHK("code_kept", 7'h05, code_fuse)
  endtask
  task automatic t_refuse;
    for (int op = 1; op < 4; op++)
    begin
      run_cmd(op[1:0], 7'h02, 1'b0);
      `CHK("refused_err", 1'b1, got_err)
      `CHK("refused_cycles", 0, got_cyc)
      `CHK("refused_ready", 1'b1, cmd_ready)
      `CHK("refused_blows", 8'h03, blow_cnt)
    end
    run_cmd(spfp_pkg::OP_ADDRESS, 7'h02, 1'b0);
    `CHK("addr_after_lock", 8'h02, sel_addr)
    `CHK("addr_after_lock_err", 1'b0, got_err)
  endtask
  initial
  begin
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_code = 7'h00;
    cmd_negative = 1'b0;
    num_errors = 0;
    checks = 0;
    cyc_cnt = 0;
    t_reset();
    t_address();
    t_blow_zero();
    t_blow_code();
    t_lock();
    t_refuse();
    `CHK("pulse_faults", 8'h00, fault_cnt)
    final_report();
  end
endmodule // tb_top
